// file: tbsp_fill_track.sv
/*
  Write and read pointers and fill level of the circular store.
  Assumes writes and reads never fall in the same cycle.
*/
`timescale 1ns/1ps

module tbsp_fill_track #(
  parameter int unsigned ADDR_W = 6
) (
  input wire logic i_ref_clk,          // core clock
  input wire logic i_rst_n,            // async reset, active low
  input wire logic i_clear,            // empty the store
  input wire logic i_wr,               // one word written at o_wptr
  input wire logic i_rd,               // one word read at o_rptr
  input wire logic i_overwrite,        // a write into a full store drops the oldest
  output logic [ADDR_W-1:0] o_wptr,    // next write address
  output logic [ADDR_W-1:0] o_rptr,    // next read address
  output logic [ADDR_W:0] o_count      // words stored
);
  import tbsp_pkg::*;

  localparam logic [ADDR_W:0] DEPTH = (ADDR_W+1)'(1) << ADDR_W;

  logic [ADDR_W-1:0] next_wptr;
  logic [ADDR_W-1:0] next_rptr;
  logic [ADDR_W:0] next_count;

  always_comb
  begin
    next_wptr = o_wptr;
    next_rptr = o_rptr;
    next_count = o_count;
    if (i_clear)
    begin
      next_wptr = '0;
      next_rptr = '0;
      next_count = '0;
    end
    else if (i_wr)
    begin
      next_wptr = o_wptr + ADDR_W'(1);
      // a full circular store keeps its level and loses its oldest word
      if (o_count == DEPTH && i_overwrite)
      begin
        next_rptr = o_rptr + ADDR_W'(1);
      end
      else
      begin
        next_count = o_count + (ADDR_W+1)'(1);
      end
    end
    else if (i_rd)
    begin
      next_rptr = o_rptr + ADDR_W'(1);
      next_count = o_count - (ADDR_W+1)'(1);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_wptr <= '0;
      o_rptr <= '0;
      o_count <= '0;
    end
    else
    begin
      o_wptr <= next_wptr;
      o_rptr <= next_rptr;
      o_count <= next_count;
    end
  end

endmodule : tbsp_fill_track

// file: tbsp_pair_buf.sv
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes the consumer pops only while o_out_valid is high.
*/
`timescale 1ns/1ps

module tbsp_pair_buf #(
  parameter int unsigned WIDTH = 32
) (
  input wire logic i_ref_clk,              // core clock
  input wire logic i_rst_n,                // async reset, active low
  input wire logic i_in_valid,             // producer offers a word
  input wire logic [WIDTH-1:0] i_in_data,  // offered word
  output logic o_in_ready,                 // space for one word, registered
  output logic o_out_valid,                // a word is held
  output logic [WIDTH-1:0] o_out_data,     // oldest held word
  input wire logic i_out_ready,            // consumer takes the oldest word
  output logic [1:0] o_count               // words held, registered
);
  import tbsp_pkg::*;

  logic [WIDTH-1:0] store [TBSP_BUF_ENTRIES];
  logic [WIDTH-1:0] next_store [TBSP_BUF_ENTRIES];
  logic wr_idx;
  logic rd_idx;
  logic next_wr_idx;
  logic next_rd_idx;
  logic [1:0] next_count;
  logic next_in_ready;
  logic push;
  logic pop;

  assign o_out_valid = (o_count != 2'h0);
  assign o_out_data = store[rd_idx];

  always_comb
  begin
    push = i_in_valid && o_in_ready;
    pop = i_out_ready && o_out_valid;
    next_store = store;
    next_wr_idx = wr_idx;
    next_rd_idx = rd_idx;
    next_count = o_count;
    if (push)
    begin
      next_store[wr_idx] = i_in_data;
      next_wr_idx = ~wr_idx;
    end
    if (pop)
    begin
      next_rd_idx = ~rd_idx;
    end
    if (push && !pop)
    begin
      next_count = o_count + 2'h1;
    end
    else if (pop && !push)
    begin
      next_count = o_count - 2'h1;
    end
    next_in_ready = (next_count != 2'h2);
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      store <= '{default: '0};
      wr_idx <= 1'b0;
      rd_idx <= 1'b0;
      o_count <= 2'h0;
      o_in_ready <= 1'b1;
    end
    else
    begin
      store <= next_store;
      wr_idx <= next_wr_idx;
      rd_idx <= next_rd_idx;
      o_count <= next_count;
      o_in_ready <= next_in_ready;
    end
  end

endmodule : tbsp_pair_buf

// file: tbsp_pkg.sv
/*
  Shared constants and types of the trace buffer SRAM port.
  Assumes one clock domain; every user of these names imports the package.
*/
package tbsp_pkg;

  // ==========================================================
  // build-time defaults
  localparam int unsigned TBSP_TRACE_W_DEF = 32;
  localparam longint unsigned TBSP_MEM_BYTES_DEF = 64'd512;
  localparam longint unsigned TBSP_MEM_BYTES_MIN = 64'd512;
  localparam longint unsigned TBSP_MEM_BYTES_MAX = 64'h1_0000_0000;
  localparam int unsigned TBSP_MARGIN_W = 32;
  localparam int unsigned TBSP_BUF_ENTRIES = 2;

  // ==========================================================
  // memory slot phases, write slot first after reset
  localparam logic TBSP_WRITE_SLOT = 1'b0;
  localparam logic TBSP_READ_SLOT = 1'b1;

  // ==========================================================
  // modes and states
  typedef enum logic {
    TBSP_CIRCULAR = 1'b0,
    TBSP_HW_FIFO = 1'b1
  } tbsp_mode_type;

  typedef enum logic [1:0] {
    TBSP_IDLE = 2'b00,
    TBSP_RUNNING = 2'b01,
    TBSP_STOPPING = 2'b10,
    TBSP_STOPPED = 2'b11
  } tbsp_state_type;

  // ==========================================================
  // configuration carried from the register side
  typedef struct packed {
    logic capture_en;
    tbsp_mode_type mode;
    logic stop_on_trig;
    logic integ_mode;
    logic integ_full;
    logic integ_done;
    logic [TBSP_MARGIN_W-1:0] full_margin;
  } tbsp_cfg_type;

  localparam tbsp_cfg_type TBSP_CFG_RESET = '{
    capture_en: 1'b0,
    mode: TBSP_CIRCULAR,
    stop_on_trig: 1'b0,
    integ_mode: 1'b0,
    integ_full: 1'b0,
    integ_done: 1'b0,
    full_margin: 32'h0000_0000
  };

endpackage : tbsp_pkg

// file: tbsp_sram_model.sv
/*
  Single-ported synchronous memory behind the memory port.
  Assumes one clock and the active-low select and write of the port.
*/
`timescale 1ns/1ps

module tbsp_sram_model #(
  parameter int AW = 6,
  parameter int DW = 64
) (
  input wire logic i_ref_clk,                 // core clock
  input wire logic i_mem_select_n,            // select, active low
  input wire logic i_mem_write_n,             // write, active low
  input wire logic [AW-1:0] i_mem_addr_bus,   // word address
  input wire logic [DW-1:0] i_mem_write_word, // write data
  output logic [DW-1:0] o_mem_read_word       // read data
);
  // ==========================================================
  // storage
  logic [DW-1:0] mem [2**AW];

  initial o_mem_read_word = '0;

  always @(posedge i_ref_clk)
  begin
    if (!i_mem_select_n && !i_mem_write_n)
      mem[i_mem_addr_bus] <= i_mem_write_word;
    // bus is not held: a late capture sees scrambled data
    if (!i_mem_select_n && i_mem_write_n)
      o_mem_read_word <= mem[i_mem_addr_bus];
    else
      o_mem_read_word <= ~o_mem_read_word;
  end
endmodule : tbsp_sram_model

// file: tbsp_top.sv
/*
  Trace buffer SRAM port: packs trace words into double-width memory
  words, stores them in an external single-ported SRAM and drains them.
  Assumes a synchronous SRAM with one cycle read latency and no turnaround,
  and a register block on the same clock that drives i_cfg.
*/
// Overview of operation
// R1: storage lives in an external single-ported SRAM reached through the memory port
// R2: the SRAM returns read data in the cycle after the address
// R3: the SRAM allows a write and a read in back-to-back cycles
// R4: memory word is twice the trace width
// R5: mem_select_n is low in every cycle with a memory access
// R6: mem_write_n low for writes, high for reads while selected
// R7: write data is presented with its address and write strobe
// R8: writes and reads alternate; read data is caught during the next write slot
// R9: every memory port output comes straight from a flip-flop
// R10: trace width is a build parameter of 32, 64 or 128 bits
// R11: capacity is a power of two from 512 bytes to 4 gigabytes
// R12: a drain output port of trace width reads the store out
// R13: everything runs on the one clock input
// R14: one active-low reset clears the whole block
// R15: configuration is taken only on apb_clock_enable cycles
// R16: full output rises at full or within the programmed margin
// R17: capture_done_out rises once capture has stopped
// R18: trigger_in reports a trigger condition from the cross-trigger logic
// R19: flush_request_in asks for held trace to be flushed
// R20: core logic idles unless in use; the configuration side always runs
// R21: outside integration mode, full output mirrors the full status flag
// R22: outside integration mode, capture_done_out mirrors formatter_drained_flag
// R23: address width is log2 of capacity over memory word bytes
`timescale 1ns/1ps

module tbsp_top #(
  parameter int unsigned trace_width_param = tbsp_pkg::TBSP_TRACE_W_DEF,
  parameter longint unsigned MEM_BYTES = tbsp_pkg::TBSP_MEM_BYTES_DEF,
  parameter int unsigned ADDR_W = $clog2(MEM_BYTES / (trace_width_param / 4))
) (
  input wire logic i_ref_clk,                            // single core clock
  input wire logic i_rst_n,                              // async reset, active low
  input wire logic i_apb_clock_enable,                   // register side cycle enable
  input wire tbsp_pkg::tbsp_cfg_type i_cfg,              // configuration from registers
  input wire logic i_trigger_in,                         // trigger condition seen
  input wire logic i_flush_request_in,                   // flush request
  input wire logic i_atb_valid,                          // trace word offered
  input wire logic [trace_width_param-1:0] i_atb_data,   // trace word
  output logic o_atb_ready,                              // trace word accepted
  output logic o_drain_valid,                            // drained word valid
  output logic [trace_width_param-1:0] o_drain_data,     // drained word
  input wire logic i_drain_ready,                        // drain sink takes word
  output logic o_mem_select_n,                           // memory select, active low
  output logic o_mem_write_n,                            // memory write, active low
  output logic [ADDR_W-1:0] o_mem_addr_bus,              // memory word address
  output logic [2*trace_width_param-1:0] o_mem_write_word, // memory write data
  input wire logic [2*trace_width_param-1:0] i_mem_read_word, // memory read data
  output logic o_full,                                   // full indication
  output logic o_capture_done_out,                       // capture complete
  output logic o_formatter_drained_flag,                 // status: pipeline empty
  output logic o_full_flag,                              // status: full
  output logic [ADDR_W:0] o_fill_level,                  // status: words stored
  output logic o_core_clock_on                           // core logic active
);
  import tbsp_pkg::*;

  localparam int unsigned TW = trace_width_param;
  localparam int unsigned MW = 2 * TW; // R4
  localparam longint unsigned DEPTH = MEM_BYTES / (TW / 4); // R23

  // ==========================================================
  // build checks
  if (!(TW == 32 || TW == 64 || TW == 128))
  begin : g_bad_width
    $error("trace width must be 32, 64 or 128"); // R10
  end
  if (MEM_BYTES < TBSP_MEM_BYTES_MIN || MEM_BYTES > TBSP_MEM_BYTES_MAX
      || (MEM_BYTES & (MEM_BYTES - 64'd1)) != 64'd0)
  begin : g_bad_size
    $error("capacity must be a power of two, 512 bytes to 4 GB"); // R11
  end
  if (longint'(64'd1 << ADDR_W) != DEPTH)
  begin : g_bad_addr
    $error("address width does not match capacity"); // R23
  end

  // ==========================================================
  // configuration side, always clocked
  tbsp_cfg_type cfg;
  tbsp_cfg_type next_cfg;

  always_comb
  begin
    next_cfg = cfg;
    if (i_apb_clock_enable)
    begin
      next_cfg = i_cfg; // R15
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cfg <= TBSP_CFG_RESET; // R14
    end
    else
    begin
      cfg <= next_cfg; // R13
    end
  end

  // ==========================================================
  // buffers and pointer tracking
  logic in_valid;
  logic [TW-1:0] in_data;
  logic take;
  logic ob_valid;
  logic [MW-1:0] ob_data;
  logic ob_pop;
  logic [1:0] ob_count;
  logic rd_inflight;
  // high in the cycle in which the memory shows the word read two edges back
  logic rd_capture;
  logic next_rd_capture;
  logic wr_issue;
  logic rd_issue;
  logic clear_ptrs;
  logic [ADDR_W-1:0] wptr;
  logic [ADDR_W-1:0] rptr;

  tbsp_pair_buf #(.WIDTH(TW)) u_in_buf (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(i_atb_valid),
    .i_in_data(i_atb_data),
    .o_in_ready(o_atb_ready),
    .o_out_valid(in_valid),
    .o_out_data(in_data),
    .i_out_ready(take),
    .o_count()
  );

  // space is reserved before a read issues, so this buffer never refuses
  tbsp_pair_buf #(.WIDTH(MW)) u_out_buf (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(rd_capture),
    .i_in_data(i_mem_read_word), // R2 R8
    .o_in_ready(),
    .o_out_valid(ob_valid),
    .o_out_data(ob_data),
    .i_out_ready(ob_pop),
    .o_count(ob_count)
  );

  tbsp_fill_track #(.ADDR_W(ADDR_W)) u_fill (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_clear(clear_ptrs),
    .i_wr(wr_issue),
    .i_rd(rd_issue),
    .i_overwrite(cfg.mode == TBSP_CIRCULAR),
    .o_wptr(wptr),
    .o_rptr(rptr),
    .o_count(o_fill_level)
  );

  // ==========================================================
  // capture control, packing and memory sequencing
  tbsp_state_type state;
  tbsp_state_type next_state;
  logic phase;
  logic next_phase;
  logic low_valid;
  logic next_low_valid;
  logic [TW-1:0] low_word;
  logic [TW-1:0] next_low_word;
  logic pend_valid;
  logic next_pend_valid;
  logic [MW-1:0] pend_word;
  logic [MW-1:0] next_pend_word;
  logic flush_pend;
  logic next_flush_pend;
  logic next_core_on;
  logic next_sel_n;
  logic next_write_n;
  logic [ADDR_W-1:0] next_addr;
  logic [MW-1:0] next_wdata;
  logic next_rd_inflight;
  logic store_full;
  logic drain_ok;
  logic pend_free;
  logic flush_pad;
  logic [32:0] lvl_sum;
  logic next_full_flag;
  logic next_drained;

  always_comb
  begin
    next_state = state;
    clear_ptrs = 1'b0;
    case (state)
      TBSP_IDLE:
      begin
        if (cfg.capture_en)
        begin
          next_state = TBSP_RUNNING;
          clear_ptrs = 1'b1;
        end
      end
      TBSP_RUNNING:
      begin
        if (!cfg.capture_en || (i_trigger_in && cfg.stop_on_trig)) // R18
        begin
          next_state = TBSP_STOPPING;
        end
      end
      TBSP_STOPPING:
      begin
        if (!low_valid && !pend_valid)
        begin
          next_state = TBSP_STOPPED;
        end
      end
      TBSP_STOPPED:
      begin
        if (!cfg.capture_en)
        begin
          next_state = TBSP_IDLE;
        end
      end
      default:
      begin
        next_state = TBSP_IDLE;
      end
    endcase
  end

  always_comb
  begin
    store_full = (o_fill_level == (ADDR_W+1)'(DEPTH));
    // a hardware FIFO drains while live, a circular store only once stopped
    drain_ok = (cfg.mode == TBSP_HW_FIFO) ? (state != TBSP_IDLE) : (state == TBSP_STOPPED);
    wr_issue = o_core_clock_on && phase == TBSP_WRITE_SLOT && pend_valid
               && !(cfg.mode == TBSP_HW_FIFO && store_full); // R8
    rd_issue = o_core_clock_on && phase == TBSP_READ_SLOT && drain_ok
               && o_fill_level != '0
               && (ob_count == 2'h0
                   || (ob_count == 2'h1 && !rd_inflight && !rd_capture)); // R8
    pend_free = !pend_valid || wr_issue;
    take = o_core_clock_on && state == TBSP_RUNNING && in_valid
           && (!low_valid || pend_free);
    flush_pad = low_valid && !take && pend_free
                && (flush_pend || state == TBSP_STOPPING); // R19
    next_low_valid = low_valid;
    next_low_word = low_word;
    next_pend_valid = pend_valid && !wr_issue;
    next_pend_word = pend_word;
    if (take && !low_valid)
    begin
      next_low_valid = 1'b1;
      next_low_word = in_data;
    end
    else if (take)
    begin
      // first word of a pair goes in the low half
      next_pend_word = {in_data, low_word}; // R4
      next_pend_valid = 1'b1;
      next_low_valid = 1'b0;
    end
    else if (flush_pad)
    begin
      next_pend_word = {{TW{1'b0}}, low_word};
      next_pend_valid = 1'b1;
      next_low_valid = 1'b0;
    end
    // a request arriving while the last one completes is kept
    next_flush_pend = (flush_pend && low_valid && !flush_pad)
                      || (i_flush_request_in && state == TBSP_RUNNING); // R19
    next_phase = o_core_clock_on ? ~phase : TBSP_WRITE_SLOT;
    next_sel_n = !(wr_issue || rd_issue); // R5
    next_write_n = !wr_issue; // R6
    next_addr = o_mem_addr_bus;
    next_wdata = o_mem_write_word;
    if (wr_issue)
    begin
      next_addr = wptr;
      next_wdata = pend_word; // R7
    end
    else if (rd_issue)
    begin
      next_addr = rptr;
    end
    next_rd_inflight = rd_issue;
    // the word stands on the read bus only in the cycle after its address
    next_rd_capture = rd_inflight; // R2
    next_core_on = cfg.capture_en || state != TBSP_IDLE || o_fill_level != '0
                   || ob_valid || rd_inflight || rd_capture || o_drain_valid; // R20
    lvl_sum = 33'(o_fill_level) + 33'(cfg.full_margin);
    next_full_flag = (lvl_sum >= 33'(DEPTH)); // R16
    next_drained = state == TBSP_STOPPED && !low_valid && !pend_valid; // R17
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state <= TBSP_IDLE;
      phase <= TBSP_WRITE_SLOT;
      low_valid <= 1'b0;
      low_word <= '0;
      pend_valid <= 1'b0;
      pend_word <= '0;
      flush_pend <= 1'b0;
      o_core_clock_on <= 1'b0;
      o_mem_select_n <= 1'b1;
      o_mem_write_n <= 1'b1;
      o_mem_addr_bus <= '0;
      o_mem_write_word <= '0;
      rd_inflight <= 1'b0;
      rd_capture <= 1'b0;
      o_full_flag <= 1'b0;
      o_formatter_drained_flag <= 1'b0;
    end
    else
    begin
      state <= next_state;
      phase <= next_phase;
      low_valid <= next_low_valid;
      low_word <= next_low_word;
      pend_valid <= next_pend_valid;
      pend_word <= next_pend_word;
      flush_pend <= next_flush_pend;
      o_core_clock_on <= next_core_on;
      o_mem_select_n <= next_sel_n; // R1 R9
      o_mem_write_n <= next_write_n; // R9
      o_mem_addr_bus <= next_addr; // R9
      o_mem_write_word <= next_wdata; // R9
      rd_inflight <= next_rd_inflight;
      rd_capture <= next_rd_capture;
      o_full_flag <= next_full_flag;
      o_formatter_drained_flag <= next_drained;
    end
  end

  // ==========================================================
  // drain output and event outputs
  logic half;
  logic next_half;
  logic next_drain_valid;
  logic [TW-1:0] next_drain_data;
  logic next_full;
  logic next_done;

  always_comb
  begin
    next_half = half;
    next_drain_valid = o_drain_valid && !i_drain_ready;
    next_drain_data = o_drain_data;
    ob_pop = 1'b0;
    if ((!o_drain_valid || i_drain_ready) && ob_valid)
    begin
      next_drain_valid = 1'b1;
      next_drain_data = half ? ob_data[MW-1:TW] : ob_data[TW-1:0]; // R12
      next_half = ~half;
      ob_pop = half;
    end
    next_full = cfg.integ_mode ? cfg.integ_full : o_full_flag; // R21
    next_done = cfg.integ_mode ? cfg.integ_done : o_formatter_drained_flag; // R22
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      half <= 1'b0;
      o_drain_valid <= 1'b0;
      o_drain_data <= '0;
      o_full <= 1'b0;
      o_capture_done_out <= 1'b0;
    end
    else
    begin
      half <= next_half;
      o_drain_valid <= next_drain_valid;
      o_drain_data <= next_drain_data;
      o_full <= next_full;
      o_capture_done_out <= next_done;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  property p_select;
    (wr_issue || rd_issue) |=> !o_mem_select_n;
  endproperty
  a_select: assert property (p_select) else $error("select not low for access"); // R5

  property p_strobe;
    !o_mem_select_n |-> (o_mem_write_n == $past(phase));
  endproperty
  a_strobe: assert property (p_strobe) else $error("write strobe wrong for slot"); // R6

  property p_wdata;
    wr_issue |=> (o_mem_write_word == $past(pend_word)
                                     && o_mem_addr_bus == $past(wptr));
  endproperty
  a_wdata: assert property (p_wdata) else $error("write data not with address"); // R7

  property p_alternate;
    (!o_mem_select_n && !o_mem_write_n) |=> (o_mem_select_n || o_mem_write_n);
  endproperty
  a_alternate: assert property (p_alternate) else $error("two writes back to back"); // R8

  property p_catch;
    (!o_mem_select_n && o_mem_write_n) |-> rd_inflight ##1 rd_capture ##1 (ob_count != 2'h0);
  endproperty
  a_catch: assert property (p_catch) else $error("read data not caught"); // R8

  property p_cfg_take;
    (cfg != $past(cfg)) |-> $past(i_apb_clock_enable);
  endproperty
  a_cfg_take: assert property (p_cfg_take) else $error("config changed off enable"); // R15

  property p_full;
    !cfg.integ_mode && $stable(cfg.integ_mode) |=> o_full == $past(o_full_flag);
  endproperty
  a_full: assert property (p_full) else $error("full output not mirroring flag"); // R21

  property p_done;
    o_capture_done_out && !cfg.integ_mode && !$past(cfg.integ_mode)
      |-> $past(state, 2) == TBSP_STOPPED;
  endproperty
  a_done: assert property (p_done) else $error("done without stop"); // R17

  property p_idle;
    !o_core_clock_on |=> o_mem_select_n;
  endproperty
  a_idle: assert property (p_idle) else $error("memory access while idle"); // R20

  property p_level;
    o_fill_level + 33'(cfg.full_margin) >= 33'(DEPTH) |=> o_full_flag;
  endproperty
  a_level: assert property (p_level) else $error("full flag missed"); // R16

endmodule : tbsp_top

// file: test_trace_buffer_sram_port.sv
/*
  Self-checking bench of the trace buffer SRAM port.
  Assumes a 512 byte store of 32 bit trace words and the memory model.
*/
`timescale 1ns/1ps

module test_trace_buffer_sram_port;
  import tbsp_pkg::*;
  localparam int TW = 32;
  localparam int AW = 6;
  logic clk = 0, rst_n = 0, en = 0, trig = 0, flush = 0, av = 0, dr = 0;
  logic [TW-1:0] ad = '0;
  tbsp_cfg_type cfg = TBSP_CFG_RESET;
  logic ardy, dv, sel_n, wr_n, full, done, fdr, ffl, con;
  logic psel_n = 1, pwr_n = 1;
  logic [TW-1:0] dd;
  logic [AW-1:0] ma;
  logic [2*TW-1:0] mw, mr;
  logic [AW:0] fill;
  int fails = 0, compares = 0;
  logic [TW-1:0] exp_q[$];

  always #5 clk = ~clk;

  tbsp_top dut_u (.i_ref_clk(clk), .i_rst_n(rst_n), .i_apb_clock_enable(en),
    .i_cfg(cfg), .i_trigger_in(trig), .i_flush_request_in(flush),
    .i_atb_valid(av), .i_atb_data(ad), .o_atb_ready(ardy),
    .o_drain_valid(dv), .o_drain_data(dd), .i_drain_ready(dr),
    .o_mem_select_n(sel_n), .o_mem_write_n(wr_n), .o_mem_addr_bus(ma),
    .o_mem_write_word(mw), .i_mem_read_word(mr), .o_full(full),
    .o_capture_done_out(done), .o_formatter_drained_flag(fdr),
    .o_full_flag(ffl), .o_fill_level(fill), .o_core_clock_on(con));

  tbsp_sram_model #(.AW(AW), .DW(2*TW)) sram_u (.i_ref_clk(clk),
    .i_mem_select_n(sel_n), .i_mem_write_n(wr_n), .i_mem_addr_bus(ma),
    .i_mem_write_word(mw), .o_mem_read_word(mr));

  // ==========================================================
  // checks and drivers
  task chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk

  task stop_test;
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  // the sink stalls at random so the drain buffer must hold its word
  always @(negedge clk) dr <= 1'($urandom_range(0, 1));

  always @(posedge clk)
  begin
    if (rst_n && dv === 1'b1 && dr)
    begin
      chk(exp_q.size() > 0 && dd === exp_q[0], "drain word");
      if (exp_q.size() > 0)
        void'(exp_q.pop_front());
    end
    if (!sel_n && !psel_n)
      chk(wr_n !== pwr_n, "slots alternate");
    psel_n <= sel_n;
    pwr_n <= wr_n;
  end

  task rst_dut;
    rst_n = 0;
    exp_q.delete();
    repeat (8) @(negedge clk);
    chk(sel_n === 1'b1 && wr_n === 1'b1 && dv === 1'b0, "reset values");
    rst_n = 1;
  endtask : rst_dut

  task set_cfg(input tbsp_cfg_type c);
    cfg = c;
    en = 1;
    @(negedge clk);
    en = 0;
    repeat (2) @(negedge clk);
  endtask : set_cfg

  task sendn(input int n);
    for (int i = 0; i < n; i++)
    begin
      av = 1;
      ad = $urandom;
      while (ardy !== 1'b1)
        @(negedge clk);
      exp_q.push_back(ad);
      @(negedge clk);
    end
    av = 0;
    @(negedge clk);
  endtask : sendn

  task waitq;
    for (int i = 0; i < 3000 && exp_q.size() > 0; i++)
      @(negedge clk);
    chk(exp_q.size() == 0, "drain complete");
  endtask : waitq

  // ==========================================================
  // tests
  initial
  begin
    void'($urandom(32'h2a8b));
    rst_dut();
    cfg.capture_en = 1;
    cfg.mode = TBSP_HW_FIFO;
    repeat (4) @(negedge clk);
    chk(con === 1'b0, "cfg taken without enable");
    set_cfg(cfg);
    chk(con === 1'b1, "core active");
    sendn(40);
    sendn(1);
    flush = 1;
    @(negedge clk);
    flush = 0;
    exp_q.push_back('0);
    waitq();
    rst_dut();
    set_cfg('{1'b1, TBSP_CIRCULAR, 1'b1, 1'b0, 1'b0, 1'b0, 32'h4});
    sendn(118);
    repeat (6) @(negedge clk);
    chk(full === 1'b0 && ffl === 1'b0, "full too early");
    sendn(2);
    repeat (6) @(negedge clk);
    chk(full === 1'b1 && ffl === 1'b1 && fill === 7'd60, "full margin");
    trig = 1;
    @(negedge clk);
    trig = 0;
    for (int i = 0; i < 200 && done !== 1'b1; i++)
      @(negedge clk);
    chk(done === 1'b1 && fdr === 1'b1, "capture done");
    waitq();
    rst_dut();
    set_cfg('{1'b0, TBSP_CIRCULAR, 1'b0, 1'b1, 1'b1, 1'b1, 32'h0});
    chk(full === 1'b1 && done === 1'b1, "integration drive");
    stop_test();
  end

  initial
  begin
    #300_000;
    fails++;
    $display("mismatch at %0t: watchdog", $time);
    stop_test();
  end
endmodule : test_trace_buffer_sram_port
